// file: verilog/srm_top.v
/*
 * srm_top.v: signal routing matrix of a protection relay: soft input
 * and output bits, output routing matrix with latches, blocking matrix.
 * Source vector, low to high: stage levels, synchronised digital inputs,
 * logic outputs, settled soft inputs, registered soft outputs.
 * Destination vector, low to high: relays, indicators, recorder trigger,
 * soft outputs; only relays and indicators can latch.
 * Arc trips bypass both matrices and are only registered.
 * Assumes all sources come from logic on CLK except DIN, which are pins
 * and are synchronised here; release commands are on CLK.
 */
`timescale 1ns/1ps
`include "srm_map.vh"

module srm_top #(
	parameter VIN_DELAY = `SRM_VIN_DELAY_CYC
) (
	input wire CLK,
	input wire RST_N,
	input wire [`SRM_N_VIN-1:0] VIN_WDATA,
	input wire VIN_WE,
	input wire [`SRM_N_VOUT-1:0] VOUT_WDATA,
	input wire VOUT_WE,
	input wire FORCE_EN,
	input wire [`SRM_N_STAGE-1:0] STAGE_ACT,
	input wire [`SRM_N_ARC-1:0] ARC_TRIP,
	input wire [`SRM_N_DIN-1:0] DIN,
	input wire [`SRM_N_LOGIC-1:0] LOGIC_OUT,
	input wire [`SRM_N_SRC*`SRM_N_DST-1:0] ROUTE_SEL,
	input wire [`SRM_N_LATCHABLE-1:0] LATCH_CFG,
	input wire [`SRM_N_SRC*`SRM_N_STAGE-1:0] BLOCK_SEL,
	input wire [`SRM_N_DIN-1:0] REL_DIN_SEL,
	input wire REL_PANEL,
	input wire REL_COMM,
	input wire VIN_EVT_EN,
	input wire VOUT_EVT_EN,
	output reg [`SRM_N_VIN-1:0] SOFT_INPUT_BITS,
	output reg [`SRM_N_VOUT-1:0] SOFT_OUTPUT_BITS,
	output reg [`SRM_N_RELAY-1:0] RELAY_OUT,
	output reg [`SRM_N_IND-1:0] IND_OUT,
	output reg FAULT_RECORDER_TRIGGER,
	output reg [`SRM_N_STAGE-1:0] STAGE_BLOCK,
	output reg [`SRM_N_ARC-1:0] ARC_TRIP_OUT,
	output reg VIN_EVENT,
	output reg VOUT_EVENT
);

// ****************
// soft bit state
// ****************
reg [`SRM_N_VIN-1:0] vin_set;
wire [`SRM_N_VIN-1:0] vin_eff;
reg [`SRM_N_VOUT-1:0] vout_force;
wire [`SRM_N_VOUT-1:0] next_vout;
wire vin_chg;
wire vout_chg;

// ****************
// digital input synchroniser state
// ****************
reg [`SRM_N_DIN-1:0] din_s1;
reg [`SRM_N_DIN-1:0] din_s2;
reg [`SRM_N_DIN-1:0] din_s3;
reg [`SRM_N_DIN-1:0] din_q;

// ****************
// matrix and latch state
// ****************
wire [`SRM_N_SRC-1:0] src;
wire [`SRM_N_DST-1:0] dst;
wire [`SRM_N_STAGE-1:0] blk;
wire [`SRM_N_LATCHABLE-1:0] lat_raw;
reg [`SRM_N_LATCHABLE-1:0] lat_hold;
wire [`SRM_N_LATCHABLE-1:0] lat_keep;
wire [`SRM_N_LATCHABLE-1:0] lat_out;
wire release_all;

// ****************
// soft input bits
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		vin_set <= `SRM_VIN_RST;
	end else if (VIN_WE) begin
		vin_set <= VIN_WDATA;
	end
end

// settling delay, whole word on one counter
srm_settle #(
	.W(`SRM_N_VIN),
	.DELAY(VIN_DELAY)
) u_settle (
	.clk(CLK),
	.rst_n(RST_N),
	.din(vin_set),
	.dout(vin_eff)
);

// ****************
// digital input synchroniser
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		din_s1 <= {`SRM_N_DIN{1'b0}};
		din_s2 <= {`SRM_N_DIN{1'b0}};
		din_s3 <= {`SRM_N_DIN{1'b0}};
		din_q <= {`SRM_N_DIN{1'b0}};
	end else begin
		din_s1 <= DIN;
		din_s2 <= din_s1;
		din_s3 <= din_s2;
		din_q <= (din_s2 & din_s3) | (din_q & (din_s2 | din_s3));
	end
end

// ****************
// source vector
// ****************
assign src = {SOFT_OUTPUT_BITS, vin_eff, LOGIC_OUT, din_q,
	STAGE_ACT};

// ****************
// routing matrix
// ****************
genvar d;
generate
	for (d = 0; d < `SRM_N_DST; d = d + 1) begin : g_dst
		assign dst[d] =
			|(src & ROUTE_SEL[d*`SRM_N_SRC +: `SRM_N_SRC]);
	end
endgenerate

// ****************
// blocking matrix, arc stages have no column here
// ****************
generate
	for (d = 0; d < `SRM_N_STAGE; d = d + 1) begin : g_blk
		assign blk[d] =
			|(src & BLOCK_SEL[d*`SRM_N_SRC +: `SRM_N_SRC]);
	end
endgenerate

// ****************
// latches
// ****************
assign release_all = REL_PANEL | REL_COMM | |(din_q & REL_DIN_SEL);

// ****************
// latch state
// ****************
assign lat_raw = dst[`SRM_DST_RELAY_POS +: `SRM_N_LATCHABLE];

always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		lat_hold <= {`SRM_N_LATCHABLE{1'b0}};
	end else if (release_all) begin
		lat_hold <= {`SRM_N_LATCHABLE{1'b0}};
	end else begin
		lat_hold <= lat_hold | (lat_raw & LATCH_CFG);
	end
end

// release masks the held part in the same cycle it is seen
assign lat_keep = lat_hold & LATCH_CFG &
	~{`SRM_N_LATCHABLE{release_all}};

// hold ORed with live source so latched outputs go on without delay
assign lat_out = lat_raw | lat_keep;

// ****************
// soft output bits
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		vout_force <= `SRM_VOUT_RST;
	end else if (!FORCE_EN) begin
		vout_force <= `SRM_VOUT_RST;
	end else if (VOUT_WE) begin
		vout_force <= VOUT_WDATA;
	end
end

// forced value is dropped whenever forcing is off
assign next_vout = FORCE_EN ? vout_force :
	dst[`SRM_DST_VOUT_POS +: `SRM_N_VOUT];

// ****************
// change detect for events
// ****************
assign vin_chg = vin_eff != SOFT_INPUT_BITS;
assign vout_chg = next_vout != SOFT_OUTPUT_BITS;

// ****************
// soft input bit outputs
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		SOFT_INPUT_BITS <= `SRM_VIN_RST;
	end else begin
		SOFT_INPUT_BITS <= vin_eff;
	end
end

// ****************
// soft output bit outputs
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		SOFT_OUTPUT_BITS <= `SRM_VOUT_RST;
	end else begin
		SOFT_OUTPUT_BITS <= next_vout;
	end
end

// ****************
// relay outputs
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		RELAY_OUT <= {`SRM_N_RELAY{1'b0}};
	end else begin
		RELAY_OUT <= lat_out[`SRM_DST_RELAY_POS +: `SRM_N_RELAY];
	end
end

// ****************
// indicator outputs
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		IND_OUT <= {`SRM_N_IND{1'b0}};
	end else begin
		IND_OUT <= lat_out[`SRM_DST_IND_POS +: `SRM_N_IND];
	end
end

// ****************
// recorder trigger, never latched
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		FAULT_RECORDER_TRIGGER <= 1'b0;
	end else begin
		FAULT_RECORDER_TRIGGER <= dst[`SRM_DST_REC_POS];
	end
end

// ****************
// stage inhibits
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		STAGE_BLOCK <= {`SRM_N_STAGE{1'b0}};
	end else begin
		STAGE_BLOCK <= blk;
	end
end

// ****************
// arc trips, outside both matrices
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		ARC_TRIP_OUT <= {`SRM_N_ARC{1'b0}};
	end else begin
		ARC_TRIP_OUT <= ARC_TRIP;
	end
end

// ****************
// soft input event pulse
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		VIN_EVENT <= 1'b0;
	end else begin
		VIN_EVENT <= VIN_EVT_EN & vin_chg;
	end
end

// ****************
// soft output event pulse
// ****************
always @(posedge CLK or negedge RST_N) begin
	if (!RST_N) begin
		VOUT_EVENT <= 1'b0;
	end else begin
		VOUT_EVENT <= VOUT_EVT_EN & vout_chg;
	end
end

endmodule

// file: pkg/srm_map.vh
/*
 * srm_map.vh: constants of the signal routing matrix: widths, source
 * index layout, reset values and timing counts.
 * Assumes a 100 MHz system clock and is included by its bare name.
 */
`ifndef SRM_MAP_VH
`define SRM_MAP_VH

// ****************
// widths
// ****************
`define SRM_N_VIN 4
`define SRM_N_VOUT 6
`define SRM_N_STAGE 8
`define SRM_N_ARC 2
`define SRM_N_DIN 8
`define SRM_N_LOGIC 4
`define SRM_N_RELAY 4
`define SRM_N_IND 2

// ****************
// source vector layout
// ****************
`define SRM_SRC_STAGE_POS 0
`define SRM_SRC_DIN_POS 8
`define SRM_SRC_LOGIC_POS 16
`define SRM_SRC_VIN_POS 20
`define SRM_SRC_VOUT_POS 24
`define SRM_N_SRC 30

// ****************
// destination vector layout
// ****************
`define SRM_DST_RELAY_POS 0
`define SRM_DST_IND_POS 4
`define SRM_DST_REC_POS 6
`define SRM_DST_VOUT_POS 7
`define SRM_N_DST 13
`define SRM_N_LATCHABLE 6

// ****************
// reset values
// ****************
`define SRM_VIN_RST 4'h0
`define SRM_VOUT_RST 6'h00

// ****************
// timing
// ****************
`define SRM_CLK_MHZ 100
`define SRM_VIN_DELAY_US 5000
`define SRM_VIN_DELAY_CYC (`SRM_VIN_DELAY_US * `SRM_CLK_MHZ)

`endif

// file: verilog/srm_settle.v
/*
 * srm_settle.v: word-wide settling delay for the soft input bits; the
 * output follows its input once the whole input has held steady the full delay.
 * Assumes input and output on the same system clock.
 */
`timescale 1ns/1ps

module srm_settle #(
	parameter W = 4,
	parameter DELAY = 500000
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] din,
	output reg [W-1:0] dout
);

reg [W-1:0] hold;
reg [19:0] cnt;

// ****************
// restart on any change, take value at end of delay
// ****************
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		hold <= {W{1'b0}};
		dout <= {W{1'b0}};
		cnt <= 20'h00000;
	end else if (din != hold) begin
		hold <= din;
		cnt <= 20'h00000;
	end else if (hold != dout) begin
		if (cnt >= DELAY[19:0] - 20'h00001) begin
			dout <= hold;
			cnt <= 20'h00000;
		end else begin
			cnt <= cnt + 20'h00001;
		end
	end
end

endmodule

// file: dv/srm_properties.sv
/* srm_properties.sv: port assertions for srm_top.
   Assumes a bind from the bench and the single clock CLK. */
`timescale 1ns/1ps
module srm_props (
	input wire CLK,
	input wire RST_N,
	input wire [7:0] STAGE_ACT,
	input wire [3:0] LOGIC_OUT,
	input wire [1:0] ARC_TRIP,
	input wire [1:0] ARC_TRIP_OUT,
	input wire [389:0] ROUTE_SEL,
	input wire [5:0] LATCH_CFG,
	input wire [3:0] RELAY_OUT,
	input wire REL_PANEL,
	input wire REL_COMM,
	input wire [7:0] REL_DIN_SEL,
	input wire VIN_EVT_EN,
	input wire VIN_EVENT,
	input wire VOUT_EVT_EN,
	input wire VOUT_EVENT,
	input wire [3:0] SOFT_INPUT_BITS,
	input wire FORCE_EN,
	input wire VOUT_WE,
	input wire [5:0] VOUT_WDATA,
	input wire [5:0] SOFT_OUTPUT_BITS
);
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	wire no_rel = !REL_PANEL && !REL_COMM && REL_DIN_SEL == 8'h00;
	wire live1 = |({LOGIC_OUT, 8'h00, STAGE_ACT} & ROUTE_SEL[49:30]);
	wire only1 = ROUTE_SEL[45:38] == 8'h00 && ROUTE_SEL[59:50] == 10'h000;
	// ****************
	// sequences
	// ****************
	sequence force_wr;
		FORCE_EN && VOUT_WE ##1 (FORCE_EN && !VOUT_WE) [*2];
	endsequence
	// ****************
	// assertions
	// ****************
	a_arc_pass: assert property ($past(RST_N) |-> ARC_TRIP_OUT == $past(ARC_TRIP))
		else $error("arc trip not passed");
	a_latch_hold: assert property (LATCH_CFG[0] && $past(LATCH_CFG[0]) && RELAY_OUT[0] && no_rel && $past(no_rel) |=> RELAY_OUT[0])
		else $error("latch lost");
	a_release_clear: assert property ((REL_PANEL || REL_COMM) && ROUTE_SEL[29:0] == 30'h0 |=> !RELAY_OUT[0])
		else $error("latch kept");
	a_nonlatch_follow: assert property (!LATCH_CFG[1] && only1 |=> RELAY_OUT[1] == $past(live1))
		else $error("relay not following");
	a_vin_quiet: assert property (!VIN_EVT_EN [*2] |-> !VIN_EVENT)
		else $error("soft input event while off");
	a_vout_quiet: assert property (!VOUT_EVT_EN [*2] |-> !VOUT_EVENT)
		else $error("soft output event while off");
	a_vin_change: assert property (VIN_EVENT |-> SOFT_INPUT_BITS != $past(SOFT_INPUT_BITS))
		else $error("event without change");
	a_vout_change: assert property (VOUT_EVENT |-> SOFT_OUTPUT_BITS != $past(SOFT_OUTPUT_BITS))
		else $error("output event without change");
	a_force_write: assert property (force_wr |-> SOFT_OUTPUT_BITS == $past(VOUT_WDATA, 2))
		else $error("forced value wrong");
endmodule

// file: dv/srm_stages.sv
/* srm_stages.sv: protection stage and logic model.
   Assumes a random word from the bench. */
`timescale 1ns/1ps
module srm_stages (
	input wire clk,
	input wire rst_n,
	input wire [31:0] rnd,
	output reg [7:0] stage_act,
	output reg [3:0] logic_out,
	output reg [1:0] arc_trip
);
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_act <= 8'h00;
			logic_out <= 4'h0;
			arc_trip <= 2'h0;
		end else begin
			stage_act <= rnd[7:0];
			logic_out <= rnd[11:8];
			arc_trip <= rnd[13:12];
		end
	end
endmodule

// file: dv/testbench.sv
/* testbench.sv: srm_top against a cycle model.
   Assumes the stage model and checker compiled first. */
`timescale 1ns/1ps
module testbench;
	reg CLK = 1'b0;
	reg RST_N = 1'b0;
	reg [31:0] r = 32'h8F7F;
	reg [3:0] vin = 4'h0;
	reg [5:0] vo = 6'h00;
	reg [5:0] lcfg = 6'h00;
	reg vin_we = 1'b0, vo_we = 1'b0, frc = 1'b0;
	reg rel_p = 1'b0, rel_c = 1'b0, vin_ev = 1'b0;
	reg [389:0] route = 390'h0;
	reg [12:0] ex = 13'h0000;
	reg vo_ev = 1'b0, rw = 1'b0;
	reg [7:0] din = 8'h00, rdsel = 8'h00, eb = 8'h00;
	reg [5:0] lh = 6'h00, pv = 6'h00;
	reg [239:0] blksel = 240'h0;
	wire [7:0] stb;
	wire voe;
	wire [7:0] st;
	wire [3:0] lo, sib;
	wire [1:0] arc, arco;
	wire [12:0] dst;
	wire vin_evt;
	integer n_mismatch = 0, total_checks = 0, i, d, x;
	srm_stages u_srm_stages (.clk(CLK), .rst_n(RST_N), .rnd(r),
		.stage_act(st), .logic_out(lo), .arc_trip(arc));
	srm_top #(.VIN_DELAY(4)) u_srm_top (.CLK(CLK), .RST_N(RST_N),
		.VIN_WDATA(vin), .VIN_WE(vin_we), .VOUT_WDATA(vo), .VOUT_WE(vo_we),
		.FORCE_EN(frc), .STAGE_ACT(st), .ARC_TRIP(arc), .DIN(din),
		.LOGIC_OUT(lo), .ROUTE_SEL(route), .LATCH_CFG(lcfg),
		.BLOCK_SEL(blksel), .REL_DIN_SEL(rdsel), .REL_PANEL(rel_p),
		.REL_COMM(rel_c), .VIN_EVT_EN(vin_ev), .VOUT_EVT_EN(vo_ev),
		.SOFT_INPUT_BITS(sib), .SOFT_OUTPUT_BITS(dst[12:7]),
		.RELAY_OUT(dst[3:0]), .IND_OUT(dst[5:4]),
		.FAULT_RECORDER_TRIGGER(dst[6]), .STAGE_BLOCK(stb),
		.ARC_TRIP_OUT(arco), .VIN_EVENT(vin_evt), .VOUT_EVENT(voe));
	function [31:0] lf(input [31:0] v);
		lf = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task chk(input [95:0] nm, input [31:0] e, input [31:0] s);
		begin
			total_checks = total_checks + 1;
			if (s !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %0s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// one cycle of the model, compared after the design's edge
	task step;
		begin
			@(negedge CLK);
			pv = ex[12:7];
			for (d = 0; d < 13; d = d + 1) begin
				rw = |({lo, 8'h00, st} & route[d*30 +: 20]);
				ex[d] = rw;
				if (d < 6) begin
					ex[d] = rw | (lcfg[d] & lh[d] & ~(rel_p | rel_c));
					lh[d] = (rel_p | rel_c) ? 1'b0 : lh[d] | (rw & lcfg[d]);
				end
			end
			for (d = 0; d < 8; d = d + 1)
				eb[d] = |({lo, 8'h00, st} & blksel[d*30 +: 20]);
			chk("routed", ex, dst);
			chk("blocked", eb, stb);
			chk("vout_evt", vo_ev & (pv != ex[12:7]), voe);
			chk("arc", arc, arco);
			rel_p = r[20:18] == 3'h0;
			rel_c = 1'b0;
		end
	endtask
	initial begin
		forever #5 CLK = ~CLK;
	end
	always @(posedge CLK) r <= lf(r);
	initial begin
		#60000;
		n_mismatch = n_mismatch + 1;
		test_done;
	end
	initial begin
		repeat (16) @(negedge CLK);
		RST_N = 1'b1;
		vo_ev = 1'b1;
		for (i = 0; i < 2000; i = i + 1) begin
			step;
			if (i % 200 == 0) begin
				x = r;
				for (d = 0; d < 13; d = d + 1) begin
					x = lf(x);
					route[d*30 +: 30] = x & (x >> 9) & 30'h000F00FF;
					if (d < 8)
						blksel[d*30 +: 30] = x & (x >> 5) & 30'h000F00FF;
				end
				lcfg = x[5:0];
				rel_c = 1'b1;
			end
		end
		for (i = 0; i < 5; i = i + 1) begin
			vin = (i == 4) ? 4'h0 : vin | (4'h1 << i);
			vin_ev = i[0];
			vo_ev = i[0];
			vin_we = 1'b1;
			@(negedge CLK);
			vin_we = 1'b0;
			d = 0;
			repeat (12) begin
				@(negedge CLK);
				d = d + vin_evt;
			end
			chk("soft_in", vin, sib);
			chk("vin_evt", i[0], d);
		end
		rel_p = 1'b0;
		rel_c = 1'b1;
		@(negedge CLK);
		rel_c = 1'b0;
		route = 390'h0;
		route[8] = 1'b1;
		lcfg = 6'h01;
		din = 8'h01;
		repeat (8) @(negedge CLK);
		chk("din_route", 1'b1, dst[0]);
		din = 8'h00;
		repeat (8) @(negedge CLK);
		chk("din_latch", 1'b1, dst[0]);
		rdsel = 8'h02;
		din = 8'h02;
		repeat (8) @(negedge CLK);
		chk("din_rel", 1'b0, dst[0]);
		din = 8'h00;
		rdsel = 8'h00;
		vo = 6'h15;
		vo_we = 1'b1;
		@(negedge CLK);
		vo_we = 1'b0;
		frc = 1'b1;
		repeat (4) @(negedge CLK);
		chk("forced", 6'h00, dst[12:7]);
		vo = 6'h2A;
		vo_we = 1'b1;
		@(negedge CLK);
		vo_we = 1'b0;
		repeat (4) @(negedge CLK);
		chk("forced", 6'h2A, dst[12:7]);
		test_done;
	end
endmodule
bind srm_top srm_props u_srm_props (.*);
